// File: verilog/dac_nv_defines.svh
// constants for the quad converter load control: bus framing, layout, counts
// assumes inclusion by the package and by every design file that needs a figure
`ifndef DAC_NV_DEFINES_SVH
`define DAC_NV_DEFINES_SVH

// ==========================================================
// channel and word layout
`define NUM_CH 4
`define CH_W 2
`define CODE_W 12
`define CFG_W 4
`define ADDR_W 3
`define LAST_CH 2'h3
`define FIRST_CH 2'h0

// ==========================================================
// bus address and framing
`define DEV_ADDR_HI 4'hC
`define FACTORY_ADDR 3'h0
`define BITS_PER_BYTE 4'h8
`define BYTE_ADDR 2'h0
`define BYTE_CMD 2'h1
`define BYTE_HI 2'h2
`define BYTE_LO 2'h3

// ==========================================================
// command byte and high byte fields
`define CMD_MSB 7
`define CMD_LSB 6
`define CH_MSB 5
`define CH_LSB 4
`define HI_CFG_MSB 7
`define HI_CFG_LSB 4
`define HI_CODE_MSB 3
`define HI_CODE_LSB 0
`define HI_ADDR_MSB 2
`define HI_ADDR_LSB 0

`endif

// File: verilog/dac_nv_pkg.sv
// types shared by the load control and its non-volatile store
// assumes the defines header sits in the include path
`include "dac_nv_defines.svh"

package dac_nv_pkg;

  typedef logic [`CODE_W-1:0] code_t;
  typedef logic [`CFG_W-1:0] cfg_t;
  typedef logic [`CFG_W+`CODE_W-1:0] nv_word_t;
  typedef logic [`NUM_CH-1:0][`CODE_W-1:0] code_vec_t;
  typedef logic [`NUM_CH-1:0][`CFG_W-1:0] cfg_vec_t;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_WRITE_NV = 2'h1,
    CMD_ADDR = 2'h2,
    CMD_NONE = 2'h3
  } cmd_t;

endpackage : dac_nv_pkg

// File: verilog/nv_if.sv
// carrier between the load control and the non-volatile store
// assumes both ends run on the one system clock
`timescale 1ns/10ps
`default_nettype none
`include "dac_nv_defines.svh"

interface nv_if;
  import dac_nv_pkg::*;
  logic wr_en;
  logic [`CH_W-1:0] wr_ch;
  nv_word_t wr_word;
  logic addr_wr_en;
  logic [`ADDR_W-1:0] addr_wr;
  logic [`CH_W-1:0] rd_ch;
  nv_word_t rd_word;
  logic [`ADDR_W-1:0] addr;

  modport client (
    output wr_en, wr_ch, wr_word, addr_wr_en, addr_wr, rd_ch,
    input rd_word, addr
  );
  modport store (
    input wr_en, wr_ch, wr_word, addr_wr_en, addr_wr, rd_ch,
    output rd_word, addr
  );
endinterface : nv_if

`default_nettype wire

// File: verilog/nv_store.sv
// non-volatile store: per-channel word and bus address bits
// assumes contents survive the logic reset; factory init fills them once
`timescale 1ns/10ps
`default_nettype none
`include "dac_nv_defines.svh"

module nv_store
  import dac_nv_pkg::*;
(
  // clock and factory fill
  input wire logic i_clk_sys,
  input wire logic i_factory_init,
  // store side
  nv_if.store bus
);

  // no reset on purpose: a logic reset stands in for a power cycle
  nv_word_t mem [`NUM_CH];
  logic [`ADDR_W-1:0] addr;

  always_ff @(posedge i_clk_sys) begin
    if (i_factory_init) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        mem[i] <= '0;
      end
    end else if (bus.wr_en) begin
      mem[bus.wr_ch] <= bus.wr_word;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_factory_init) begin
      addr <= `FACTORY_ADDR;
    end else if (bus.addr_wr_en) begin
      addr <= bus.addr_wr;
    end
  end

  assign bus.rd_word = mem[bus.rd_ch];
  assign bus.addr = addr;

endmodule : nv_store

`default_nettype wire

// File: verilog/dac_load_ctrl.sv
// quad 12-bit converter digital control: two-wire write slave, input and
// output registers, power-up copy from non-volatile store, load pin.
// assumes scl, sda and the load pin are asynchronous pins; sda is open drain.
// Notes on behaviour
// - keep codes, config, address in reprogrammable storage
// - copy storage to outputs after power-up
// - answer at address with three programmable bits
// - load pin selects device for address programming
// - load pin low moves all inputs to outputs
// - load held low: outputs follow written inputs
// - twelve-bit code per channel, one millivolt step
`timescale 1ns/10ps
`default_nettype none
`include "dac_nv_defines.svh"

module dac_load_ctrl
  import dac_nv_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_factory_init,
  // two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // load pin
  input wire logic i_sync_load_n,
  // converter outputs
  output code_vec_t o_dac_code,
  output cfg_vec_t o_dac_cfg,
  output logic o_loading
);

  // ==========================================================
  // pin synchronisers
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, load_m, load_n_s;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {load_m, load_n_s} <= 2'h3;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
      {load_m, load_n_s} <= {i_sync_load_n, load_m};
    end
  end

  logic load_low, scl_rise, scl_fall, start_det, stop_det;
  assign load_low = !load_n_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // ==========================================================
  // store and power-up copy
  nv_if nv_bus ();

  nv_store u_nv_store (
    .i_clk_sys(i_clk_sys),
    .i_factory_init(i_factory_init),
    .bus(nv_bus.store)
  );

  logic loading;
  logic [`CH_W-1:0] load_idx;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loading <= 1'b1;
      load_idx <= `FIRST_CH;
    end else if (loading) begin
      load_idx <= load_idx + 2'h1;
      if (load_idx == `LAST_CH) begin
        loading <= 1'b0;
      end
    end
  end

  assign o_loading = loading;

  // ==========================================================
  // byte receiver
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK} bus_state_t;
  bus_state_t state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift;
  logic [7:0] cmd_byte;
  logic [7:0] hi_byte;
  logic byte_done, addr_match, ack_ok, commit;
  cmd_t cmd_q;
  logic [`CH_W-1:0] ch_q;

  assign byte_done = (state == ST_RX) && scl_fall && (bit_cnt == `BITS_PER_BYTE);
  assign addr_match = (shift[7:1] == {`DEV_ADDR_HI, nv_bus.addr}) && !shift[0];
  assign ack_ok = (byte_idx != `BYTE_ADDR) || addr_match;
  assign commit = byte_done && (byte_idx == `BYTE_LO);
  assign cmd_q = cmd_t'(cmd_byte[`CMD_MSB:`CMD_LSB]);
  assign ch_q = cmd_byte[`CH_MSB:`CH_LSB];

  // reads are not served: the read bit fails the match and is left unanswered
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= `BYTE_ADDR;
      shift <= 8'h00;
    end else if (loading || stop_det) begin
      state <= ST_IDLE;
    end else if (start_det) begin
      state <= ST_RX;
      bit_cnt <= 4'h0;
      byte_idx <= `BYTE_ADDR;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state <= ack_ok ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= ST_RX;
            bit_cnt <= 4'h0;
            // further commands may follow in the same transaction
            byte_idx <= (byte_idx == `BYTE_LO) ? `BYTE_CMD : byte_idx + 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda_oe <= 1'b0;
    end else if (start_det || stop_det || loading) begin
      o_sda_oe <= 1'b0;
    end else if (byte_done && ack_ok) begin
      o_sda_oe <= 1'b1;
    end else if (state == ST_ACK && scl_fall) begin
      o_sda_oe <= 1'b0;
    end
  end

  assign o_sda_o = 1'b0;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_byte <= 8'hC0;
      hi_byte <= 8'h00;
    end else if (byte_done && byte_idx == `BYTE_CMD) begin
      cmd_byte <= shift;
    end else if (byte_done && byte_idx == `BYTE_HI) begin
      hi_byte <= shift;
    end
  end

  // ==========================================================
  // input registers and store writes
  code_vec_t in_code;
  cfg_vec_t in_cfg;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_code <= '0;
      in_cfg <= '0;
    end else if (loading) begin
      {in_cfg[load_idx], in_code[load_idx]} <= nv_bus.rd_word;
    end else if (commit && (cmd_q == CMD_WRITE || cmd_q == CMD_WRITE_NV)) begin
      in_code[ch_q] <= {hi_byte[`HI_CODE_MSB:`HI_CODE_LSB], shift};
      in_cfg[ch_q] <= hi_byte[`HI_CFG_MSB:`HI_CFG_LSB];
    end
  end

  assign nv_bus.rd_ch = load_idx;
  assign nv_bus.wr_en = commit && (cmd_q == CMD_WRITE_NV);
  assign nv_bus.wr_ch = ch_q;
  assign nv_bus.wr_word = {hi_byte, shift};
  // bus writes change the address bits only while this device is picked by its load pin
  assign nv_bus.addr_wr_en = commit && (cmd_q == CMD_ADDR) && load_low;
  assign nv_bus.addr_wr = hi_byte[`HI_ADDR_MSB:`HI_ADDR_LSB];

  // ==========================================================
  // output registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dac_code <= '0;
      o_dac_cfg <= '0;
    end else if (loading) begin
      {o_dac_cfg[load_idx], o_dac_code[load_idx]} <= nv_bus.rd_word;
    end else if (load_low) begin
      // level transfer: a pin held low makes outputs track every write
      o_dac_code <= in_code;
      o_dac_cfg <= in_cfg;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  // checks the stored word itself, not just the strobe
  property p_nv_write;
    commit && cmd_q == CMD_WRITE_NV |=>
      u_nv_store.mem[$past(ch_q)] == $past({hi_byte, shift});
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("store write missed");

  // the release edge itself still samples reset low and must not start an attempt
  property p_copy_len;
    i_arst_n && loading && load_idx == `FIRST_CH |-> loading [*4] ##1 !loading;
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("power-up copy length wrong");

  property p_copy_done;
    $fell(loading) |-> o_dac_code == in_code && o_dac_cfg == in_cfg;
  endproperty
  a_copy_done: assert property (p_copy_done) else $error("outputs not loaded at power-up");

  property p_addr_ack;
    byte_done && byte_idx == `BYTE_ADDR |=> o_sda_oe == $past(addr_match);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address answer wrong");

  property p_addr_new;
    commit && cmd_q == CMD_ADDR && load_low |=>
      nv_bus.addr == $past(hi_byte[`HI_ADDR_MSB:`HI_ADDR_LSB]);
  endproperty
  a_addr_new: assert property (p_addr_new) else $error("address bits not stored");

  property p_addr_sel;
    commit && cmd_q == CMD_ADDR && !load_low |=> $stable(nv_bus.addr);
  endproperty
  a_addr_sel: assert property (p_addr_sel) else $error("address changed unselected");

  property p_load_move;
    !loading && load_low |=> o_dac_code == $past(in_code) && o_dac_cfg == $past(in_cfg);
  endproperty
  a_load_move: assert property (p_load_move) else $error("load did not move inputs");

  property p_follow;
    (commit && cmd_q == CMD_WRITE && load_low) ##1 load_low |=>
      o_dac_code[$past(ch_q, 2)] ==
        {$past(hi_byte[`HI_CODE_MSB:`HI_CODE_LSB], 2), $past(shift, 2)};
  endproperty
  a_follow: assert property (p_follow) else $error("output did not follow write");

  property p_hold;
    !loading && !load_low |=> $stable(o_dac_code);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without load");

  c_copy: cover property ($fell(loading));
  c_write: cover property (commit && cmd_q == CMD_WRITE);
  c_addr: cover property (nv_bus.addr_wr_en);
  c_nack: cover property (byte_done && !ack_ok);

endmodule : dac_load_ctrl

`default_nettype wire

// File: tb/i2c_host_model.sv
// two-wire bus host model: start, byte with acknowledge, stop, write frame
// assumes sda is open drain with a pull-up and that this host alone drives scl
`timescale 1ns/10ps
`default_nettype none
`include "dac_nv_defines.svh"

module i2c_host_model
  import dac_nv_pkg::*;
#(
  parameter int HALF = 10
) (
  // clock
  input wire logic i_clk_sys,
  // bus pins
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ==========================================================
  // bit level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge i_clk_sys);
  endtask : wait_half

  // sda moves two cycles after scl falls so the synchronisers never see both at once
  task automatic clock_bit(input logic v, output logic seen);
    o_sda <= v;
    wait_half();
    o_scl <= 1'b1;
    repeat (HALF / 2) @(posedge i_clk_sys);
    seen = i_sda;
    repeat (HALF - HALF / 2) @(posedge i_clk_sys);
    o_scl <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask : clock_bit

  task automatic bus_start();
    o_sda <= 1'b0;
    wait_half();
    o_scl <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask : bus_start

  task automatic bus_stop();
    o_sda <= 1'b0;
    wait_half();
    o_scl <= 1'b1;
    wait_half();
    o_sda <= 1'b1;
    wait_half();
  endtask : bus_stop

  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    acked = !seen;
  endtask : send_byte

  // ==========================================================
  // frame level
  // gives up at the first missing acknowledge
  task automatic write_frame(input logic [2:0] addr, input cmd_t cmd, input logic [1:0] ch,
                             input logic [7:0] hi, input logic [7:0] lo, output logic ok);
    logic [3:0][7:0] bytes;
    logic a;
    bytes = {{`DEV_ADDR_HI, addr, 1'b0}, {cmd, ch, 4'h0}, hi, lo};
    ok = 1'b1;
    bus_start();
    for (int k = 3; k >= 0; k--) begin
      if (ok) begin
        send_byte(bytes[k], a);
        ok = a;
      end
    end
    bus_stop();
  endtask : write_frame
endmodule : i2c_host_model

`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the quad converter load control
// assumes a host model on the bus pins and the load pin driven from here
`timescale 1ns/10ps
`default_nettype none
`include "dac_nv_defines.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb;
  import dac_nv_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_factory_init = 1'b1;
  logic i_sync_load_n = 1'b1;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic sda_o;
  logic sda_oe;
  code_vec_t dac_code;
  cfg_vec_t dac_cfg;
  logic loading;
  int miscompares = 0;
  int checks_done = 0;

  // open drain data line with pull-up
  assign sda_line = host_sda & ~(sda_oe & ~sda_o);
  always #2 i_clk_sys = ~i_clk_sys;

  dac_load_ctrl dac_load_ctrl_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_factory_init(i_factory_init), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_sync_load_n(i_sync_load_n), .o_dac_code(dac_code),
    .o_dac_cfg(dac_cfg), .o_loading(loading));

  i2c_host_model i2c_host_model_i (.i_clk_sys(i_clk_sys), .i_sda(sda_line), .o_scl(scl),
    .o_sda(host_sda));

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // reset stands in for a power cycle; the store keeps its words unless fill asks for factory init
  task automatic power_up(input logic fill);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    i_factory_init <= fill;
    repeat (20) @(posedge i_clk_sys);
    `CHECK(loading, 1'b1)
    i_factory_init <= 1'b0;
    @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    for (int n = 0; n < 20 && loading !== 1'b0; n++) @(posedge i_clk_sys);
    `CHECK(loading, 1'b0)
    repeat (3) @(posedge i_clk_sys);
  endtask : power_up

  task automatic write(input logic [2:0] addr, input cmd_t cmd, input logic [1:0] ch,
                       input logic [7:0] hi, input logic [7:0] lo, input logic exp_ack);
    logic ok;
    i2c_host_model_i.write_frame(addr, cmd, ch, hi, lo, ok);
    `CHECK(ok, exp_ack)
    repeat (4) @(posedge i_clk_sys);
  endtask : write

  task automatic set_load(input logic v);
    @(posedge i_clk_sys);
    i_sync_load_n <= v;
    repeat (8) @(posedge i_clk_sys);
  endtask : set_load

  // ==========================================================
  // scenarios
  task automatic t_power_up();
    power_up(1'b1);
    `CHECK(dac_code, code_vec_t'(0))
    `CHECK(dac_cfg, cfg_vec_t'(0))
  endtask : t_power_up

  task automatic t_track();
    logic [1:0] ch;
    set_load(1'b0);
    for (int k = 0; k < 4; k++) begin
      ch = k[1:0];
      write(`FACTORY_ADDR, CMD_WRITE, ch, {4'h8 + 4'(ch), 4'hF - 4'(ch)}, 8'hFF, 1'b1);
      `CHECK(dac_code[ch], {4'hF - 4'(ch), 8'hFF})
      `CHECK(dac_cfg[ch], 4'h8 + 4'(ch))
    end
  endtask : t_track

  task automatic t_sync_load();
    set_load(1'b1);
    write(`FACTORY_ADDR, CMD_WRITE, 2'h0, 8'h08, 8'h00, 1'b1);
    write(`FACTORY_ADDR, CMD_WRITE, 2'h2, 8'h30, 8'h01, 1'b1);
    `CHECK(dac_code[0], 12'hFFF)
    `CHECK(dac_code[2], 12'hDFF)
    // short low pulse: outputs must latch together, then hold
    @(posedge i_clk_sys);
    i_sync_load_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_sync_load_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    `CHECK(dac_code[0], 12'h800)
    `CHECK(dac_code[2], 12'h001)
    `CHECK(dac_cfg[2], 4'h3)
    `CHECK(dac_code[1], 12'hEFF)
  endtask : t_sync_load

  task automatic t_nv_restore();
    set_load(1'b0);
    write(`FACTORY_ADDR, CMD_WRITE_NV, 2'h3, 8'hAA, 8'hBC, 1'b1);
    write(`FACTORY_ADDR, CMD_WRITE, 2'h3, 8'h01, 8'h11, 1'b1);
    `CHECK(dac_code[3], 12'h111)
    power_up(1'b0);
    `CHECK(dac_code[3], 12'hABC)
    `CHECK(dac_cfg[3], 4'hA)
    `CHECK(dac_code[0], 12'h000)
  endtask : t_nv_restore

  task automatic t_address();
    set_load(1'b1);
    write(`FACTORY_ADDR, CMD_ADDR, 2'h0, 8'h05, 8'h00, 1'b1);
    write(3'h5, CMD_WRITE, 2'h0, 8'h01, 8'h00, 1'b0);
    set_load(1'b0);
    write(`FACTORY_ADDR, CMD_ADDR, 2'h0, 8'h05, 8'h00, 1'b1);
    write(`FACTORY_ADDR, CMD_WRITE, 2'h0, 8'h01, 8'h00, 1'b0);
    write(3'h5, CMD_WRITE, 2'h0, 8'h02, 8'h34, 1'b1);
    `CHECK(dac_code[0], 12'h234)
    // the idle command is acknowledged but must leave the channel alone
    write(3'h5, CMD_NONE, 2'h0, 8'h0F, 8'hFF, 1'b1);
    `CHECK(dac_code[0], 12'h234)
  endtask : t_address

  // ==========================================================
  // main sequence and watchdog
  initial begin
    t_power_up();
    t_track();
    t_sync_load();
    t_nv_restore();
    t_address();
    finish_test();
  end

  // fourteen frames of up to roughly eight hundred cycles each fit well inside this
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    miscompares++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
